// File: src/sccsp_pkg.sv
// Package of offsets, field positions and timing for the serial card control/status port
package sccsp_pkg;
    // Host address decode
    localparam int ADDR_W = 10;
    localparam logic [2:0] OFF_CTRL = 3'h4;
    localparam logic [2:0] OFF_TC_CLR = 3'h5;
    localparam logic [2:0] OFF_CTRL_LAST = 3'h3;
    // Control port fields
    localparam int CB_DTR_A = 0;
    localparam int CB_DTR_B = 1;
    localparam int CB_LL_A = 2;
    localparam int CB_RL_A = 3;
    localparam int CB_LL_B = 4;
    localparam int CB_RL_B = 5;
    localparam int CB_DMA_B = 6;
    localparam int CB_DMA_A = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Status port fields
    localparam int SB_DSR_A = 0;
    localparam int SB_DSR_B = 1;
    localparam int SB_TM_A = 2;
    localparam int SB_SC_IRQ = 3;
    localparam int SB_TM_B = 4;
    localparam int SB_TC = 5;
    localparam int SB_DMA_B = 6;
    localparam int SB_DMA_A = 7;
    // DMA enable option codes per channel
    typedef enum logic [1:0] {
        SCCSP_DMA_SOFT = 2'b00,
        SCCSP_DMA_ALWAYS = 2'b01,
        SCCSP_DMA_NEVER = 2'b10
    } sccsp_dma_opt_t;
    // Serial controller reference clock
    localparam int SYS_CLK_HZ = 125000000;
    localparam int REF_CLK_HZ = 7372800;
    localparam int NCO_W = 32;
    localparam logic [NCO_W-1:0] NCO_STEP =
        NCO_W'((64'(REF_CLK_HZ) << NCO_W) / 64'(SYS_CLK_HZ));
endpackage

// File: src/sccsp_sync.sv
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module sccsp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] stage1;

    // First stage feeds only the second
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            stage1 <= INIT;
            q_out <= INIT;
        end else if (ce_in) begin
            stage1 <= d_in;
            q_out <= stage1;
        end
    end
endmodule

// File: src/sccsp_top.sv
// Control/status port, terminal-count latch and reference clock of the serial adapter
`timescale 1ns/1ps
module sccsp_top #(
    parameter logic [9:0] BASE_ADDR = 10'h300
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    // Host I/O bus, already on sys_clk
    input wire logic [15:0] host_addr_in,
    input wire logic [7:0] host_wdata_in,
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    output logic [7:0] host_rdata_out,
    output logic host_rdata_en_out,
    output logic serial_controller_sel_out,
    // Pins from the line and controller
    input wire logic dsr_a_b_in,
    input wire logic dsr_b_b_in,
    input wire logic tm_a_b_in,
    input wire logic tm_b_b_in,
    input wire logic serial_controller_irq_b_in,
    input wire logic tc_in,
    input wire logic dack_a_b_in,
    input wire logic dack_b_b_in,
    // Jumper straps
    input wire logic irq_mode_option_tc_in,
    input wire logic [1:0] dma_enable_option_a_in,
    input wire logic [1:0] dma_enable_option_b_in,
    // Outputs
    output logic dtr_a_out,
    output logic dtr_b_out,
    output logic ll_a_out,
    output logic ll_b_out,
    output logic rl_a_out,
    output logic rl_b_out,
    output logic dma_drv_en_a_out,
    output logic dma_drv_en_b_out,
    output logic tc_irq_out,
    output logic serial_controller_clk_out
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [6:0] pins_raw;
    logic [6:0] pins;
    logic [4:0] straps_raw;
    logic [4:0] straps;
    logic dsr_a_s;
    // Raw groups in the bit order of their synchronised copies
    assign pins_raw = {tc_in, dack_b_b_in, dack_a_b_in, serial_controller_irq_b_in, tm_b_b_in, tm_a_b_in, dsr_b_b_in};
    assign straps_raw = {irq_mode_option_tc_in, dma_enable_option_b_in, dma_enable_option_a_in};
    // Pins reset to their idle level, so no false terminal count follows reset
    sccsp_sync #(.W(7), .INIT(7'h3f)) u_sync_pins (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .ce_in(ce_in),
        .d_in(pins_raw),
        .q_out(pins)
    );
    // Straps read as never until synchronised, so no driver enables during reset
    sccsp_sync #(.W(5), .INIT(5'h0a)) u_sync_straps (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .ce_in(ce_in),
        .d_in(straps_raw),
        .q_out(straps)
    );
    // Channel A DSR on its own pair, idle high like the pin
    sccsp_sync #(.W(1), .INIT(1'b1)) u_sync_dsr_a (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .ce_in(ce_in),
        .d_in(dsr_a_b_in),
        .q_out(dsr_a_s)
    );
    // Strap fields
    wire tc_opt = straps[4];
    wire [1:0] opt_b = straps[3:2];
    wire [1:0] opt_a = straps[1:0];

    ////////////////////////////////////////////////////////////////////////
    // Address decode on low ten lines only
    // Upper lines are ignored, so the card aliases every 1 KiB of I/O space
    // Offsets six and seven decode to nothing and are silently ignored
    wire [9:0] addr_lo = host_addr_in[9:0];
    wire in_window = (addr_lo[9:3] == BASE_ADDR[9:3]);
    wire [2:0] off = addr_lo[2:0];
    wire sel_ctrl = in_window && (off == sccsp_pkg::OFF_CTRL);
    wire sel_tc_clr = in_window && (off == sccsp_pkg::OFF_TC_CLR);
    assign serial_controller_sel_out = in_window && (off <= sccsp_pkg::OFF_CTRL_LAST);
    // Strobes gated by the clock enable, so a frozen block ignores the host
    wire ctrl_wr = ce_in && host_wr_in && sel_ctrl;
    wire tc_clr = ce_in && host_wr_in && sel_tc_clr;

    ////////////////////////////////////////////////////////////////////////
    // Control register
    // Whole byte taken on every write; no read-back exists, so software keeps a copy
    logic [7:0] ctrl;
    wire [7:0] next_ctrl = ctrl_wr ? host_wdata_in : ctrl;
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            ctrl <= sccsp_pkg::CTRL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end
    // Modem and loopback levels straight from the register
    assign dtr_a_out = ctrl[sccsp_pkg::CB_DTR_A];
    assign dtr_b_out = ctrl[sccsp_pkg::CB_DTR_B];
    assign ll_a_out = ctrl[sccsp_pkg::CB_LL_A];
    assign ll_b_out = ctrl[sccsp_pkg::CB_LL_B];
    assign rl_a_out = ctrl[sccsp_pkg::CB_RL_A];
    assign rl_b_out = ctrl[sccsp_pkg::CB_RL_B];

    ////////////////////////////////////////////////////////////////////////
    // DMA driver enables per strap option
    // The spare option code counts as never, so a bad strap cannot enable DMA
    wire soft_a = (opt_a == sccsp_pkg::SCCSP_DMA_SOFT);
    wire fixed_on_a = (opt_a == sccsp_pkg::SCCSP_DMA_ALWAYS);
    wire soft_b = (opt_b == sccsp_pkg::SCCSP_DMA_SOFT);
    wire fixed_on_b = (opt_b == sccsp_pkg::SCCSP_DMA_ALWAYS);
    // Software enable bits matter only in the software option
    wire en_a = fixed_on_a || (soft_a && ctrl[sccsp_pkg::CB_DMA_A]);
    wire en_b = fixed_on_b || (soft_b && ctrl[sccsp_pkg::CB_DMA_B]);
    assign dma_drv_en_a_out = en_a;
    assign dma_drv_en_b_out = en_b;

    ////////////////////////////////////////////////////////////////////////
    // Terminal-count latch; set wins over a simultaneous clear
    // The count belongs to whichever channel has its acknowledge low in that cycle
    wire tc_s = pins[6];
    wire dack_a_on = !pins[4];
    wire dack_b_on = !pins[5];
    wire tc_hit = tc_opt && tc_s && ((en_a && dack_a_on) || (en_b && dack_b_on));
    logic tc_latch;
    logic next_tc_latch;
    // Next latch value; a lost count would hang the driver, so set has priority
    always_comb begin
        next_tc_latch = tc_latch;
        if (tc_hit) begin
            next_tc_latch = 1'b1;
        end else if (tc_clr) begin
            next_tc_latch = 1'b0;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            tc_latch <= 1'b0;
        end else if (ce_in) begin
            tc_latch <= next_tc_latch;
        end
    end
    assign tc_irq_out = tc_latch;

    ////////////////////////////////////////////////////////////////////////
    // Status read, registered
    wire [7:0] status;
    // Line inputs pass through at their pin level, active low
    assign status[sccsp_pkg::SB_DSR_A] = dsr_a_s;
    assign status[sccsp_pkg::SB_DSR_B] = pins[0];
    assign status[sccsp_pkg::SB_TM_A] = pins[1];
    assign status[sccsp_pkg::SB_TM_B] = pins[2];
    assign status[sccsp_pkg::SB_SC_IRQ] = pins[3];
    // Latch and enables inverted so that zero means on
    assign status[sccsp_pkg::SB_TC] = ~tc_latch;
    assign status[sccsp_pkg::SB_DMA_B] = ~en_b;
    assign status[sccsp_pkg::SB_DMA_A] = ~en_a;
    // Only a read of offset four answers; other reads see zero data
    wire status_rd = host_rd_in && sel_ctrl;
    wire [7:0] next_rdata = status_rd ? status : 8'h00;
    // Data and strobe registered together so they stand in the same cycle
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            host_rdata_out <= 8'h00;
            host_rdata_en_out <= 1'b0;
        end else if (ce_in) begin
            host_rdata_en_out <= status_rd;
            host_rdata_out <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reference clock by phase accumulator; jitter of one sys_clk period traded for no PLL
    // Average frequency exact to the step's resolution; edges land on sys_clk edges only
    // Restarts from zero at reset, so the first edge after reset is known
    logic [sccsp_pkg::NCO_W-1:0] phase;
    wire [sccsp_pkg::NCO_W-1:0] next_phase = phase + sccsp_pkg::NCO_STEP;
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            phase <= '0;
        end else if (ce_in) begin
            phase <= next_phase;
        end
    end
    assign serial_controller_clk_out = phase[sccsp_pkg::NCO_W-1];
endmodule

// File: test/sccsp_dma_model.sv
// Behavioural system DMA controller ending a block on one channel
`timescale 1ns/1ps
module sccsp_dma_model (
    input wire logic sys_clk_in,
    input wire logic [1:0] req_in,
    output logic tc_out = 1'b0,
    output logic dack_a_b_out = 1'b1,
    output logic dack_b_b_out = 1'b1
);
    int cnt = 0;
    logic [1:0] ch = 2'b00;
    // Last transfer: acknowledge with terminal count four cycles, then idle high
    always @(posedge sys_clk_in) begin
        if (cnt == 0 && req_in != 2'b00) begin
            cnt = 4;
            ch = req_in;
        end else if (cnt > 0) cnt = cnt - 1;
        tc_out <= cnt > 0;
        dack_a_b_out <= !(cnt > 0 && ch[0]);
        dack_b_b_out <= !(cnt > 0 && ch[1]);
    end
endmodule

// File: test/sccsp_properties.sv
// Concurrent checks on the control/status port pins
`timescale 1ns/1ps
module sccsp_props #(
    parameter logic [9:0] BASE_ADDR = 10'h300
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    input wire logic tc_in,
    input wire logic dack_a_b_in,
    input wire logic [15:0] host_addr_in,
    input wire logic [7:0] host_wdata_in,
    input wire logic [7:0] host_rdata_out,
    input wire logic host_rdata_en_out,
    input wire logic serial_controller_sel_out,
    input wire logic irq_mode_option_tc_in,
    input wire logic tc_irq_out,
    input wire logic [1:0] dma_enable_option_a_in,
    input wire logic dtr_a_out,
    input wire logic dtr_b_out,
    input wire logic ll_a_out,
    input wire logic ll_b_out,
    input wire logic rl_a_out,
    input wire logic rl_b_out,
    input wire logic dma_drv_en_a_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    // Only the low ten lines take part, so upper bits alias
    wire logic hit4 = ce_in && host_addr_in[9:0] == BASE_ADDR + 10'h4;
    wire logic clr = host_wr_in && ce_in && host_addr_in[9:0] == BASE_ADDR + 10'h5;
    wire logic [5:0] ctl = {rl_b_out, ll_b_out, rl_a_out, ll_a_out, dtr_b_out, dtr_a_out};
    // Terminal count seen through the pin synchronisers
    sequence tc_quiet; (!tc_in)[*4]; endsequence
    // A clear in the same cycle must lose to the set
    sequence tc_hit_a; (tc_in && !dack_a_b_in && irq_mode_option_tc_in && dma_drv_en_a_out)[*3]; endsequence
    sel_decode_a: assert property (serial_controller_sel_out == (host_addr_in[9:2] == BASE_ADDR[9:2]))
        else $error("controller select wrong");
    rd_answer_a: assert property (host_rd_in && hit4 |=> host_rdata_en_out) else $error("read not answered");
    rd_idle_a: assert property (!(host_rd_in && hit4) |=> !host_rdata_en_out && host_rdata_out == 8'h00)
        else $error("read data without read");
    ctrl_write_a: assert property (host_wr_in && hit4 |=> ctl == $past(host_wdata_in[5:0]))
        else $error("control bits wrong");
    ctrl_hold_a: assert property (!(host_wr_in && hit4) |=> $stable(ctl)) else $error("control moved");
    tc_clear_a: assert property (tc_quiet ##0 clr |=> !tc_irq_out) else $error("latch not cleared");
    tc_set_a: assert property (tc_hit_a |=> tc_irq_out) else $error("latch not set");
    tc_hold_a: assert property (tc_irq_out && !clr |=> tc_irq_out) else $error("latch dropped");
    ce_freeze_a: assert property (!ce_in |=> $stable(tc_irq_out) && $stable(host_rdata_out))
        else $error("state moved while frozen");
    dma_never_a: assert property ($stable(dma_enable_option_a_in)[*4] ##0 dma_enable_option_a_in[1] |->
        !dma_drv_en_a_out) else $error("dma enabled when never");
    dma_always_a: assert property ($stable(dma_enable_option_a_in)[*4] ##0
        dma_enable_option_a_in == sccsp_pkg::SCCSP_DMA_ALWAYS |-> dma_drv_en_a_out) else $error("dma off when always");
endmodule

// File: test/serial_card_control_status_port_tb.sv
// Self-checking bench for the control/status port
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin n_fail++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module serial_card_control_status_port_tb;
    localparam logic [9:0] BASE = 10'h300;
    logic sys_clk_in = 0, rst_b_in = 0, wr = 0, rd = 0, irq_mode = 0, den, rd_en, sel, tc_irq, sc_clk, ena, enb;
    logic ce = 1;
    logic [7:0] nx;
    logic [15:0] addr = '0;
    logic [7:0] wdata = '0, rdata, rd_q, d;
    logic [4:0] pins = 5'h1f;
    logic [1:0] opt_a = 0, opt_b = 0, req = 0;
    wire [5:0] ctl;
    wire tc, dack_a, dack_b;
    int n_fail = 0, num_checks = 0, m_ctrl = 0, m_tc = 0, i, k, e;
    longint w;
    always #4 sys_clk_in = ~sys_clk_in;
    sccsp_top #(.BASE_ADDR(BASE)) DUT (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .ce_in(ce),
        .host_addr_in(addr), .host_wdata_in(wdata), .host_wr_in(wr), .host_rd_in(rd), .host_rdata_out(rd_q),
        .host_rdata_en_out(rd_en), .serial_controller_sel_out(sel), .dsr_a_b_in(pins[0]), .dsr_b_b_in(pins[1]),
        .tm_a_b_in(pins[2]), .serial_controller_irq_b_in(pins[3]), .tm_b_b_in(pins[4]), .tc_in(tc),
        .dack_a_b_in(dack_a), .dack_b_b_in(dack_b), .irq_mode_option_tc_in(irq_mode),
        .dma_enable_option_a_in(opt_a), .dma_enable_option_b_in(opt_b), .dtr_a_out(ctl[0]), .dtr_b_out(ctl[1]),
        .ll_a_out(ctl[2]), .rl_a_out(ctl[3]), .ll_b_out(ctl[4]), .rl_b_out(ctl[5]), .dma_drv_en_a_out(ena),
        .dma_drv_en_b_out(enb), .tc_irq_out(tc_irq), .serial_controller_clk_out(sc_clk));
    sccsp_dma_model dma_i (.sys_clk_in(sys_clk_in), .req_in(req), .tc_out(tc), .dack_a_b_out(dack_a),
        .dack_b_b_out(dack_b));
    ////////////////////////////////////////////////////////////////////////////////
    // One host cycle; read data stands for one cycle only, so it is caught here
    task automatic bus(input logic [15:0] a, input logic [7:0] dv, input logic wv);
        @(negedge sys_clk_in);
        addr = a;
        wdata = dv;
        wr = wv;
        rd = !wv;
        @(negedge sys_clk_in);
        wr = 0;
        rd = 0;
        rdata = rd_q;
        den = rd_en;
    endtask
    // Expected status byte from the model state
    function automatic logic [7:0] stat();
        logic a, b;
        a = opt_a == 2'b00 ? m_ctrl[7] : opt_a == 2'b01;
        b = opt_b == 2'b00 ? m_ctrl[6] : opt_b == 2'b01;
        return {!a, !b, !m_tc[0], pins};
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        k = $urandom(32'h39e93657);
        repeat (6) @(negedge sys_clk_in);
        rst_b_in = 1;
        repeat (3) @(negedge sys_clk_in);
        `CHK("reset ctl", 6'h00, ctl)
        bus(BASE + 10'h4, 8'h00, 0);
        `CHK("reset stat", stat(), rdata)
        $display("test reset done");
        // Random writes through aliased addresses, then offsets other than four and five must not touch the port
        for (i = 0; i < 24; i++) begin
            d = 8'($urandom);
            pins = 5'($urandom);
            opt_a = 2'(i % 3);
            opt_b = 2'((i + 1) % 3);
            bus({6'($urandom), BASE + 10'h4}, d, 1);
            m_ctrl = d;
            `CHK("ctl", d[5:0], ctl)
            repeat (3) @(negedge sys_clk_in);
            bus({6'($urandom), BASE + 10'h4}, 8'h00, 0);
            `CHK("stat", stat(), rdata)
            `CHK("rd en", 1'b1, den)
            nx = ~stat();
            `CHK("dma en", nx[7:6], {ena, enb})
            k = i % 8;
            if (k != 4 && k != 5) begin
                bus({6'($urandom), BASE + 10'(k)}, ~d, 1);
                `CHK("sel", 1'(k < 4), sel)
                bus({6'($urandom), BASE + 10'(k)}, 8'h00, 0);
                `CHK("other ctl", d[5:0], ctl)
                `CHK("other rd", 9'h000, {den, rdata})
            end
        end
        $display("test port done");
        // Terminal count per channel and interrupt option
        opt_a = 0;
        opt_b = 2;
        bus(BASE + 10'h4, 8'h80, 1);
        m_ctrl = 8'h80;
        for (i = 0; i < 4; i++) begin
            irq_mode = i[0];
            req = i[1] ? 2'b10 : 2'b01;
            @(negedge sys_clk_in);
            req = 0;
            repeat (8) @(negedge sys_clk_in);
            m_tc = (i == 1);
            `CHK("tc irq", m_tc[0], tc_irq)
            bus(BASE + 10'h4, 8'h00, 0);
            `CHK("terminal_count_status", stat(), rdata)
            bus({6'($urandom), BASE + 10'h5}, 8'($urandom), 1);
            m_tc = 0;
            `CHK("tc clear", 1'b0, tc_irq)
        end
        $display("test terminal count done");
        // Frozen clock enable ignores writes; a mid-run reset restores zeros
        bus(BASE + 10'h4, 8'hff, 1);
        m_ctrl = 8'hff;
        `CHK("dma on", 1'b1, ena)
        ce = 0;
        bus(BASE + 10'h4, 8'h00, 1);
        `CHK("ce freeze", 6'h3f, ctl)
        ce = 1;
        rst_b_in = 0;
        repeat (6) @(negedge sys_clk_in);
        rst_b_in = 1;
        m_ctrl = 0;
        repeat (3) @(negedge sys_clk_in);
        `CHK("reset ctl 2", 6'h00, ctl)
        `CHK("reset dma", 1'b0, ena)
        $display("test freeze and reset done");
        // Reference clock rising edges over a fixed span
        k = 0;
        e = 0;
        for (i = 0; i < 12500; i++) begin
            @(negedge sys_clk_in);
            k += (sc_clk && e == 0);
            e = sc_clk;
        end
        w = longint'(12500) * sccsp_pkg::REF_CLK_HZ / sccsp_pkg::SYS_CLK_HZ;
        `CHK("ref clk", 1'b1, 1'(k >= w && k <= w + 1))
        $display("test ref clock done");
        tally_and_finish();
    end
endmodule
bind sccsp_top sccsp_props #(.BASE_ADDR(BASE_ADDR)) props_i (.*);
